// *** hw/display_host_interface_select.sv ***
// Purpose: Host interface of a graphic display controller with four strap-selected bus styles.
// Assumes: All host pins are synchronous to clock; straps change only while initialization runs.
// Notes: Accepted bytes leave on a registered strobe; reads return a byte from the core.
`timescale 1ns/1ps
module display_host_interface_select
    import host_port_pkg::*;
(
    input wire logic clock, // System clock, 50 MHz.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic bus_style_sel_a, // Bus style strap A.
    input wire logic bus_style_sel_b, // Bus style strap B.
    input wire logic init_in_n, // Host initialization input, active low.
    input wire logic chip_sel_n, // Chip select, active low.
    input wire logic data_cmd, // High for display data, low for command.
    input wire logic enable_rd, // 68xx enable, active high, or 80xx read strobe, active low.
    input wire logic rw_wr, // 68xx read/write select or 80xx write strobe.
    input wire logic [7:0] host_bus_lines_i, // Host bus input levels.
    output logic [7:0] host_bus_lines_o, // Host bus output levels.
    output logic [7:0] host_bus_lines_oe_n, // Host bus output enable, low drives.
    input wire logic [7:0] read_byte, // Byte the core offers for reads.
    output logic byte_valid, // One-cycle pulse with a taken byte.
    output logic [7:0] byte_out, // Taken byte.
    output logic byte_is_data, // Taken byte is display data.
    output logic read_taken, // One-cycle pulse when a read is served.
    output logic in_init, // High while initialization runs.
    output bus_style_t bus_style // Latched bus style.
);

    // ************************************************************
    // Timing overview
    // ************************************************************
    // The two strobe pins and the serial clock are each sampled once per clock and compared with their last sample.
    // An edge is therefore seen one cycle after the pin moves.
    // The action it triggers shows on the outputs one cycle later again.
    // Each strobe level must stand for at least one clock as a result.
    // A shorter pulse can slip between samples and is then lost without notice.
    //
    // In 68xx style the enable pin opens a cycle on its rising edge.
    // A read starts the drive there, so the byte stands while enable is high.
    // A write is taken on the falling edge of enable, when the data have settled.
    //
    // In 80xx style the read strobe starts the drive on its falling edge.
    // The drive ends when the read strobe rises again.
    // A write is taken when the write strobe rises, at the end of the strobe.
    //
    // In both serial styles bit 0 of the host bus is the clock and bit 1 the data.
    // Bits are taken on the rising clock edge, first bit first.
    // The 4-wire style reads the data/command pin together with the eighth bit.
    // The 3-wire style has no such pin, so the first bit of a frame marks the byte.
    // That flag bit also stays in the data field, which users must allow for.
    //
    // Chip select high, or a running initialization, clears the bit count.
    // It also lets go of the bus, and a partial serial byte is dropped silently.
    // The straps are read only during initialization.
    // A later change of the straps has no effect until the next initialization.

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        bus_style_t style;
        logic init;
        logic [7:0] shift;
        logic [2:0] bitcnt;
        logic [7:0] drive;
        logic drive_en;
        byte_word_t out;
        logic valid;
        logic rd_taken;
    } port_state_t;

    port_state_t s_q;
    port_state_t s_d;
    logic en_rise;
    logic en_fall;
    logic wr_rise;
    logic wr_fall;
    logic sclk_rise;
    logic cs_active;

    // Edge detectors for the two strobes and the serial clock.
    edge_detect u_en (
        .clock(clock),
        .nrst(nrst),
        .level(enable_rd),
        .rise(en_rise),
        .fall(en_fall)
    );

    edge_detect u_wr (
        .clock(clock),
        .nrst(nrst),
        .level(rw_wr),
        .rise(wr_rise),
        .fall(wr_fall)
    );

    edge_detect u_sclk (
        .clock(clock),
        .nrst(nrst),
        .level(host_bus_lines_i[SER_CLK_BIT]),
        .rise(sclk_rise),
        .fall()
    );

    // Chip select gates every transfer.
    assign cs_active = ~chip_sel_n & ~s_q.init;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.valid = 1'b0;
        s_d.rd_taken = 1'b0;
        s_d.init = ~init_in_n;
        if (!init_in_n) begin
            // Initialization clears the port and captures the straps.
            s_d.shift = BYTE_RESET;
            s_d.bitcnt = BITCNT_RESET;
            s_d.drive = BYTE_RESET;
            s_d.drive_en = 1'b0;
            s_d.out = '0;
            case ({bus_style_sel_a, bus_style_sel_b})
                STRAP_SPI3: s_d.style = BUS_SPI3;
                STRAP_SPI4: s_d.style = BUS_SPI4;
                STRAP_P68: s_d.style = BUS_P68;
                STRAP_P80: s_d.style = BUS_P80;
                default: s_d.style = BUS_SPI4;
            endcase
        end else if (!cs_active) begin
            // Deselect aborts a partial serial byte and releases the bus.
            s_d.bitcnt = BITCNT_RESET;
            s_d.drive_en = 1'b0;
        end else begin
            case (s_q.style)
                BUS_P68: begin
                    // Enable high opens a cycle; rw_wr gives the direction.
                    if (en_rise && rw_wr) begin
                        s_d.drive = read_byte;
                        s_d.drive_en = 1'b1;
                        s_d.rd_taken = 1'b1;
                    end
                    if (en_fall && !rw_wr) begin
                        s_d.out.data = host_bus_lines_i;
                        s_d.out.is_data = data_cmd;
                        s_d.valid = 1'b1;
                    end
                    if (en_fall && rw_wr) begin
                        s_d.drive_en = 1'b0;
                    end
                end
                BUS_P80: begin
                    // Read strobe low drives the bus until it rises.
                    if (en_fall) begin
                        s_d.drive = read_byte;
                        s_d.drive_en = 1'b1;
                        s_d.rd_taken = 1'b1;
                    end
                    if (en_rise) begin
                        s_d.drive_en = 1'b0;
                    end
                    // Write data is taken on the closing edge of the strobe.
                    if (wr_rise) begin
                        s_d.out.data = host_bus_lines_i;
                        s_d.out.is_data = data_cmd;
                        s_d.valid = 1'b1;
                    end
                end
                default: begin
                    // Serial modes shift MSB first on the clock's rising edge.
                    if (sclk_rise) begin
                        s_d.shift = {s_q.shift[6:0], host_bus_lines_i[SER_DAT_BIT]};
                        s_d.bitcnt = s_q.bitcnt + 3'h1;
                        if (s_q.bitcnt == BITCNT_LAST) begin
                            s_d.out.data = {s_q.shift[6:0], host_bus_lines_i[SER_DAT_BIT]};
                            if (s_q.style == BUS_SPI4) begin
                                s_d.out.is_data = data_cmd;
                            end else begin
                                s_d.out.is_data = s_q.shift[6]; // First bit of this frame.
                            end
                            s_d.valid = 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // Register the state.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.init <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from the state register.
    assign host_bus_lines_o = s_q.drive;
    assign host_bus_lines_oe_n = {8{~s_q.drive_en}};
    assign byte_valid = s_q.valid;
    assign byte_out = s_q.out.data;
    assign byte_is_data = s_q.out.is_data;
    assign read_taken = s_q.rd_taken;
    assign in_init = s_q.init;
    assign bus_style = s_q.style;
endmodule

// *** hw/edge_detect.sv ***
// Purpose: Registered level and edge flags for one host strobe line.
// Assumes: Input is synchronous to clock.
// Notes: Rise and fall are one-cycle pulses, held in registers.
`timescale 1ns/1ps
module edge_detect
    import host_port_pkg::*;
(
    input wire logic clock, // System clock.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic level, // Sampled line.
    output logic rise, // One cycle after a low to high change.
    output logic fall // One cycle after a high to low change.
);

    typedef struct packed {
        logic prev;
        logic rise;
        logic fall;
    } edge_state_t;

    edge_state_t s_q;
    edge_state_t s_d;

    // Compare the line against its last sample.
    always_comb begin
        s_d = s_q;
        s_d.prev = level;
        s_d.rise = level & ~s_q.prev;
        s_d.fall = ~level & s_q.prev;
    end

    // Register the state.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rise = s_q.rise;
    assign fall = s_q.fall;
endmodule

// *** hw/host_port_pkg.sv ***
// Purpose: Shared constants and types for the display host interface select block.
// Assumes: All host pins are synchronous to clock.
// Notes: Strap codes are the pair (sel_a, sel_b); bus style codes do not follow them.
package host_port_pkg;

    // ************************************************************
    // Bus styles and strap codes
    // ************************************************************
    typedef enum logic [1:0] {
        BUS_SPI4,
        BUS_SPI3,
        BUS_P80,
        BUS_P68
    } bus_style_t;

    localparam logic [1:0] STRAP_SPI3 = 2'h2; // sel_a=1, sel_b=0.
    localparam logic [1:0] STRAP_SPI4 = 2'h0;
    localparam logic [1:0] STRAP_P68 = 2'h3;
    localparam logic [1:0] STRAP_P80 = 2'h1;

    // Reset values and the last bit count.
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [2:0] BITCNT_RESET = 3'h0;
    localparam logic [2:0] BITCNT_LAST = 3'h7;

    // Serial line positions on the host bus.
    localparam int SER_CLK_BIT = 0;
    localparam int SER_DAT_BIT = 1;
    localparam int SER_DC_BIT = 2;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [7:0] data;
        logic is_data;
    } byte_word_t;

    typedef struct packed {
        logic chip_sel_n;
        logic dc;
        logic strobe_a;
        logic strobe_b;
        logic [7:0] bus_in;
    } host_pins_t;

endpackage

// *** verification/host_model.sv ***
// Purpose: Host processor model driving the display host pins.
// Assumes: Calls start just after a falling clock edge.
// Notes: Every strobe level is held at least two cycles.
`timescale 1ns/1ps
module host_model
    import host_port_pkg::*;
(
    input wire logic clock, // System clock.
    input wire logic [7:0] bus_seen, // Resolved bus lines.
    output host_pins_t pins // Host pin levels.
);
    // ************************************************************
    // Bus cycles
    // ************************************************************
    task automatic hold(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Parks the pins; serial styles keep both strobes grounded.
    task automatic idle(input logic [1:0] s);
        pins = '{1'b1, 1'b0, s == STRAP_P80, s == STRAP_P80, 8'h00};
    endtask
    // Parallel write; data is held until after the closing strobe edge.
    task automatic pwrite(input logic p68, input logic cs_n, input logic dc, input logic [7:0] b);
        pins.chip_sel_n = cs_n;
        pins.dc = dc;
        pins.bus_in = b;
        pins.strobe_b = 1'b0;
        hold(2);
        pins.strobe_a = p68 | !p68 & pins.strobe_a;
        hold(3);
        if (p68) pins.strobe_a = 1'b0;
        else pins.strobe_b = 1'b1;
        hold(3);
        pins.chip_sel_n = 1'b1;
        pins.bus_in = ~b;
        hold(2);
    endtask
    // Parallel read; the host inverts its bus levels and samples the device drive.
    task automatic pread(input logic p68, output logic [7:0] v);
        pins.chip_sel_n = 1'b0;
        pins.bus_in = ~pins.bus_in;
        pins.strobe_b = 1'b1;
        hold(2);
        pins.strobe_a = p68;
        hold(4);
        v = bus_seen;
        pins.strobe_a = !p68;
        hold(3);
        pins.chip_sel_n = 1'b1;
        hold(2);
    endtask
    // Serial byte, first bit first; the clock rests low between frames.
    task automatic spi(input logic dc, input logic [7:0] b);
        pins.chip_sel_n = 1'b0;
        pins.dc = dc;
        for (int i = 7; i >= 0; i--) begin
            pins.bus_in[1] = b[i];
            hold(2);
            pins.bus_in[0] = 1'b1;
            hold(2);
            pins.bus_in[0] = 1'b0;
        end
        hold(3);
        pins.bus_in[1] = ~b[0];
        pins.chip_sel_n = 1'b1;
        hold(2);
    endtask
endmodule

// *** verification/host_port_chk_assertions.sv ***
// Purpose: Checker for the display host interface select block.
// Assumes: Inputs are ports of the top module.
// Notes: Bound to every instance of the block.
`timescale 1ns/1ps
module host_port_chk
    import host_port_pkg::*;
(
    input wire logic clock, // System clock.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic init_in_n, // Initialization input, active low.
    input wire logic chip_sel_n, // Chip select, active low.
    input wire logic bus_style_sel_a, // Bus style strap A.
    input wire logic bus_style_sel_b, // Bus style strap B.
    input wire logic byte_valid, // Taken byte strobe.
    input wire logic byte_is_data, // Taken byte is display data.
    input wire logic read_taken, // Read served strobe.
    input wire logic in_init, // Initialization running.
    input wire logic [7:0] host_bus_lines_oe_n, // Bus output enable.
    input wire bus_style_t bus_style // Latched bus style.
);
    // ************************************************************
    // Checks
    // ************************************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // Maps a strap pair to the style it selects.
    function automatic bus_style_t style_of(input logic [1:0] s);
        return s == STRAP_SPI3 ? BUS_SPI3 : s == STRAP_P68 ? BUS_P68 : s == STRAP_P80 ? BUS_P80 : BUS_SPI4;
    endfunction
    a_style_from_strap: assert property (!init_in_n |=> bus_style == style_of($past({bus_style_sel_a, bus_style_sel_b})))
        else $error("bus style differs from straps");
    a_style_held_run: assert property (init_in_n && $past(init_in_n) |-> $stable(bus_style))
        else $error("bus style moved outside init");
    a_init_enter: assert property (!init_in_n |=> in_init)
        else $error("init not entered");
    a_init_leave: assert property ($rose(init_in_n) |=> !in_init)
        else $error("init not left");
    a_quiet_in_init: assert property (in_init && $past(in_init) |-> !byte_valid && !read_taken)
        else $error("transfer during init");
    a_quiet_no_select: assert property (chip_sel_n [*4] |-> !byte_valid && !read_taken)
        else $error("transfer without chip select");
    a_release_no_select: assert property (chip_sel_n [*4] |-> host_bus_lines_oe_n == 8'hFF)
        else $error("bus driven without chip select");
    a_valid_one_cycle: assert property (byte_valid |=> !byte_valid)
        else $error("byte strobe too long");
    a_read_one_cycle: assert property (read_taken |=> !read_taken)
        else $error("read strobe too long");
    a_drive_on_read: assert property ($fell(host_bus_lines_oe_n[0]) |-> read_taken)
        else $error("bus driven without read");
    a_enable_uniform: assert property (host_bus_lines_oe_n == 8'h00 || host_bus_lines_oe_n == 8'hFF)
        else $error("bus enables split");
    c_data_byte: cover property (byte_valid && byte_is_data);
    c_cmd_byte: cover property (byte_valid && !byte_is_data);
    c_read: cover property (read_taken);
endmodule
bind display_host_interface_select host_port_chk i_chk (.clock, .nrst, .init_in_n, .chip_sel_n, .bus_style_sel_a,
    .bus_style_sel_b, .byte_valid, .byte_is_data, .read_taken, .in_init, .host_bus_lines_oe_n, .bus_style);

// *** verification/tb.sv ***
// Purpose: Self-checking bench for the display host interface select block.
// Assumes: The host model drives all bus pins at falling edges.
// Notes: Rows cover every bus style with data and command bytes.
`timescale 1ns/1ps
module tb
    import host_port_pkg::*;
;
    typedef struct packed {logic [1:0] strap; bus_style_t style; logic dc; logic [7:0] b;} row_t;
    logic clock, nrst, sel_a, sel_b, init_n, bv, is_data, rt, in_init;
    logic [7:0] rb, o, oe_n, byte_out, bus_w, v;
    bus_style_t style;
    host_pins_t pins;
    int bad_count, cmp_count, nv, nr;
    row_t rows[8] = '{'{STRAP_SPI3, BUS_SPI3, 1'b1, 8'hC3}, '{STRAP_SPI3, BUS_SPI3, 1'b0, 8'h5A},
        '{STRAP_SPI4, BUS_SPI4, 1'b1, 8'h3C}, '{STRAP_SPI4, BUS_SPI4, 1'b0, 8'hA5},
        '{STRAP_P68, BUS_P68, 1'b1, 8'h81}, '{STRAP_P68, BUS_P68, 1'b0, 8'h7E},
        '{STRAP_P80, BUS_P80, 1'b1, 8'hFF}, '{STRAP_P80, BUS_P80, 1'b0, 8'h00}};
    display_host_interface_select i_dut (.clock(clock), .nrst(nrst), .bus_style_sel_a(sel_a),
        .bus_style_sel_b(sel_b), .init_in_n(init_n), .chip_sel_n(pins.chip_sel_n), .data_cmd(pins.dc),
        .enable_rd(pins.strobe_a), .rw_wr(pins.strobe_b), .host_bus_lines_i(bus_w), .host_bus_lines_o(o),
        .host_bus_lines_oe_n(oe_n), .read_byte(rb), .byte_valid(bv), .byte_out(byte_out),
        .byte_is_data(is_data), .read_taken(rt), .in_init(in_init), .bus_style(style));
    host_model i_host (.clock(clock), .bus_seen(bus_w), .pins(pins));
    // Resolves the shared bus lines from both drivers.
    assign bus_w = (oe_n & pins.bus_in) | (~oe_n & o);
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // Counts strobes from the block midway through each cycle, where they have settled.
    always @(negedge clock) begin
        nv += (bv === 1'b1);
        nr += (rt === 1'b1);
    end
    task automatic check(input logic [7:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Latches a style through an init pulse.
    task automatic mode(input logic [1:0] s);
        init_n = 1'b0;
        {sel_a, sel_b} = s; // Straps move only while init is held.
        i_host.idle(s);
        i_host.hold(3);
        init_n = 1'b1;
        i_host.hold(3);
        nv = 0;
        nr = 0;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        results();
    end
    // Reset, the table of writes, then reads and refused writes.
    initial begin
        {nrst, init_n, sel_a, sel_b, rb, bad_count, cmp_count, nv, nr} = '0;
        i_host.idle(STRAP_SPI4);
        repeat (2) @(negedge clock);
        check({in_init, oe_n == 8'hFF, bv, rt, 4'h0}, 8'hC0);
        check(8'(style), 8'(BUS_SPI4));
        nrst = 1'b1;
        foreach (rows[i]) begin
            mode(rows[i].strap);
            check(8'(style), 8'(rows[i].style));
            if (rows[i].strap[0]) i_host.pwrite(rows[i].strap == STRAP_P68, 1'b0, rows[i].dc, rows[i].b);
            else i_host.spi(rows[i].dc, rows[i].b);
            check(8'(nv), 8'h01);
            check(byte_out, rows[i].b);
            check(8'(is_data), 8'(rows[i].dc));
        end
        rb = 8'h96;
        for (int m = 0; m < 2; m++) begin
            mode(m ? STRAP_P68 : STRAP_P80);
            i_host.pread(m == 1, v);
            check(v, 8'h96);
            check({nv[3:0], nr[3:0]}, 8'h01);
            check(oe_n, 8'hFF);
        end
        i_host.pwrite(1'b1, 1'b1, 1'b1, 8'h11);
        init_n = 1'b0;
        i_host.pwrite(1'b1, 1'b0, 1'b1, 8'h22);
        check(8'(nv), 8'h00);
        results();
    end
endmodule
